/* File: power_clock_pkg.sv */
package power_clock_pkg;

  localparam logic [31:0] POWER_KEY_FIRST_ADDR   = 32'hffff0404;
  localparam logic [31:0] POWER_MODE_ADDR        = 32'hffff0408;
  localparam logic [31:0] POWER_KEY_SECOND_ADDR  = 32'hffff040c;
  localparam logic [31:0] PLL_KEY_FIRST_ADDR     = 32'hffff0410;
  localparam logic [31:0] PLL_CONFIG_ADDR        = 32'hffff0414;
  localparam logic [31:0] PLL_KEY_SECOND_ADDR    = 32'hffff0418;
  localparam logic [31:0] PERIPH_KEY_FIRST_ADDR  = 32'hffff0434;
  localparam logic [31:0] PERIPH_CONTROL_ADDR    = 32'hffff0438;
  localparam logic [31:0] PERIPH_KEY_SECOND_ADDR = 32'hffff043c;

  localparam logic [15:0] PLL_KEY_FIRST_VALUE     = 16'h00aa;
  localparam logic [15:0] PLL_KEY_SECOND_VALUE    = 16'h0055;
  localparam logic [15:0] POWER_KEY_FIRST_VALUE   = 16'h0001;
  localparam logic [15:0] POWER_KEY_SECOND_VALUE  = 16'h00f4;
  localparam logic [15:0] PERIPH_KEY_FIRST_VALUE  = 16'h0076;
  localparam logic [15:0] PERIPH_KEY_SECOND_VALUE = 16'h00b1;

  localparam logic [7:0]  POWER_MODE_RESET    = 8'h00;
  localparam logic [7:0]  PLL_CONFIG_RESET    = 8'h21;
  localparam logic [15:0] PERIPH_CONTROL_RESET = 16'h0004;
  localparam logic [7:0]  POWER_MODE_MASK     = 8'h77;
  localparam logic [7:0]  PLL_CONFIG_MASK     = 8'h23;
  localparam logic [15:0] PERIPH_CONTROL_MASK = 16'h09ff;

  localparam int MODE_MSB         = 6;
  localparam int MODE_LSB         = 4;
  localparam int CORE_DIV_MSB     = 2;
  localparam int CORE_DIV_LSB     = 0;
  localparam int PLL_REF_BIT      = 5;
  localparam int SOURCE_MSB       = 1;
  localparam int SOURCE_LSB       = 0;
  localparam int PWM_ON_BIT       = 11;
  localparam int SPI_ON_BIT       = 8;
  localparam int SPI_DIV_MSB      = 7;
  localparam int SPI_DIV_LSB      = 6;
  localparam int TWOWIRE2_ON_BIT  = 5;
  localparam int TWOWIRE2_DIV_MSB = 4;
  localparam int TWOWIRE2_DIV_LSB = 3;
  localparam int TWOWIRE1_ON_BIT  = 2;
  localparam int TWOWIRE1_DIV_MSB = 1;
  localparam int TWOWIRE1_DIV_LSB = 0;

  localparam logic [2:0] MODE_ACTIVE = 3'h0;
  localparam logic [2:0] MODE_PAUSE  = 3'h1;
  localparam logic [2:0] MODE_NAP    = 3'h2;
  localparam logic [2:0] MODE_SLEEP  = 3'h3;
  localparam logic [2:0] MODE_STOP   = 3'h4;
  localparam logic [1:0] SOURCE_PLL      = 2'h1;
  localparam logic [1:0] SOURCE_EXTERNAL = 2'h3;

  localparam int CLOCK_MHZ             = 200;
  localparam int PAUSE_RECOVERY_CD0_NS = 230;
  localparam int NAP_RECOVERY_CD0_NS   = 283;
  localparam int SLOW_RECOVERY_CD7_NS  = 3000;
  localparam int SLEEP_RECOVERY_NS     = 1230000;
  localparam int STOP_RECOVERY_NS      = 1450000;
  localparam int PAUSE_CD0_CYCLES = (PAUSE_RECOVERY_CD0_NS * CLOCK_MHZ + 999) / 1000;
  localparam int NAP_CD0_CYCLES   = (NAP_RECOVERY_CD0_NS * CLOCK_MHZ + 999) / 1000;
  localparam int SLOW_CD7_CYCLES  = (SLOW_RECOVERY_CD7_NS * CLOCK_MHZ + 999) / 1000;
  localparam int SLEEP_CYCLES     = (SLEEP_RECOVERY_NS * CLOCK_MHZ + 999) / 1000;
  localparam int STOP_CYCLES      = (STOP_RECOVERY_NS * CLOCK_MHZ + 999) / 1000;
  localparam int CORE_DIV_TOP     = 7;

  typedef enum logic [2:0] {
    KEY_IDLE   = 3'b001,
    KEY_ARMED  = 3'b010,
    KEY_LOADED = 3'b100
  } key_state_t;

  typedef enum logic [5:0] {
    ST_ACTIVE  = 6'b000001,
    ST_PAUSE   = 6'b000010,
    ST_NAP     = 6'b000100,
    ST_SLEEP   = 6'b001000,
    ST_STOP    = 6'b010000,
    ST_RECOVER = 6'b100000
  } mode_state_t;

endpackage

/* File: key_sequencer.sv */
`timescale 1ns/1ps
module key_sequencer #(
  parameter logic [15:0] FIRST_KEY  = 16'h0000,
  parameter logic [15:0] SECOND_KEY = 16'h0000
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        first_hit,
  input  wire logic        value_hit,
  input  wire logic        second_hit,
  input  wire logic        read_hit,
  input  wire logic [15:0] wdata,
  output logic      [15:0] value_q,
  output logic             commit_q
);
  power_clock_pkg::key_state_t state_q;
  power_clock_pkg::key_state_t state_d;
  wire first_ok  = first_hit && (wdata == FIRST_KEY);
  wire second_ok = second_hit && (wdata == SECOND_KEY);
  wire touched   = first_hit | value_hit | second_hit | read_hit;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      power_clock_pkg::KEY_IDLE:
        if (first_ok) state_d = power_clock_pkg::KEY_ARMED;
      power_clock_pkg::KEY_ARMED:
        if (value_hit) state_d = power_clock_pkg::KEY_LOADED;
        else if (first_ok) state_d = power_clock_pkg::KEY_ARMED;
        else if (touched) state_d = power_clock_pkg::KEY_IDLE;
      power_clock_pkg::KEY_LOADED:
        if (second_ok) state_d = power_clock_pkg::KEY_IDLE;
        else if (first_ok) state_d = power_clock_pkg::KEY_ARMED;
        else if (touched) state_d = power_clock_pkg::KEY_IDLE;
      default: state_d = power_clock_pkg::KEY_IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q  <= power_clock_pkg::KEY_IDLE;
      value_q  <= 16'h0000;
      commit_q <= 1'b0;
    end
    else
    begin
      state_q  <= state_d;
      if (state_q == power_clock_pkg::KEY_ARMED && value_hit)
        value_q <= wdata;
      // Only the full ordered sequence commits
      commit_q <= (state_q == power_clock_pkg::KEY_LOADED) && second_ok;
    end
  end
endmodule

/* File: tick_divider.sv */
`timescale 1ns/1ps
module tick_divider #(
  parameter int WIDTH = 7
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       tick_in,
  input  wire logic       run,
  input  wire logic [2:0] shift,
  output logic            tick_q
);
  logic [WIDTH-1:0] count_q;
  wire  [WIDTH-1:0] mask = WIDTH'((1 << shift) - 1);
  wire              hit  = (count_q & mask) == '0;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      count_q <= '0;
      tick_q  <= 1'b0;
    end
    else
    begin
      if (tick_in)
        count_q <= count_q + 1'b1;
      // Gated output keeps the divided phase while halted
      tick_q <= run && tick_in && hit;
    end
  end
endmodule

/* File: power_clock_control.sv */
`timescale 1ns/1ps
module power_clock_control #(
  parameter int SLEEP_RECOVERY_CYCLES = power_clock_pkg::SLEEP_CYCLES,
  parameter int STOP_RECOVERY_CYCLES  = power_clock_pkg::STOP_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [31:0] addr,
  input  wire logic [31:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [31:0] rdata_q,
  input  wire logic        pll_output_clock,
  input  wire logic        external_clock_tick,
  input  wire logic        pll_locked,
  input  wire logic [3:0]  external_wake_interrupts,
  input  wire logic        core_wake_request,
  input  wire logic        pll_irq_ack,
  output logic             core_clock_tick_q,
  output logic             serial_periph_clock_tick_q,
  output logic             first_twowire_clock_tick_q,
  output logic             second_twowire_clock_tick_q,
  output logic             pwm_enable_q,
  output logic             serial_periph_enable_q,
  output logic             first_twowire_enable_q,
  output logic             second_twowire_enable_q,
  output logic             core_running_q,
  output logic             peripherals_running_q,
  output logic             pll_running_q,
  output logic             crystal_timers_running_q,
  output logic             wake_irqs_enabled_q,
  output logic             clock_source_external_q,
  output logic             pll_reference_internal_q,
  output logic             pll_irq_q
);
  localparam int CW = 20;

  // Address decode
  wire hit_pwr_k1 = addr == power_clock_pkg::POWER_KEY_FIRST_ADDR;
  wire hit_pwr    = addr == power_clock_pkg::POWER_MODE_ADDR;
  wire hit_pwr_k2 = addr == power_clock_pkg::POWER_KEY_SECOND_ADDR;
  wire hit_pll_k1 = addr == power_clock_pkg::PLL_KEY_FIRST_ADDR;
  wire hit_pll    = addr == power_clock_pkg::PLL_CONFIG_ADDR;
  wire hit_pll_k2 = addr == power_clock_pkg::PLL_KEY_SECOND_ADDR;
  wire hit_per_k1 = addr == power_clock_pkg::PERIPH_KEY_FIRST_ADDR;
  wire hit_per    = addr == power_clock_pkg::PERIPH_CONTROL_ADDR;
  wire hit_per_k2 = addr == power_clock_pkg::PERIPH_KEY_SECOND_ADDR;

  logic [7:0]  power_mode_q;
  logic [7:0]  pll_config_q;
  logic [15:0] periph_control_q;
  logic [15:0] pwr_value;
  logic [15:0] pll_value;
  logic [15:0] per_value;
  logic        pwr_commit;
  logic        pll_commit;
  logic        per_commit;

  key_sequencer #(
    .FIRST_KEY  (power_clock_pkg::PLL_KEY_FIRST_VALUE),
    .SECOND_KEY (power_clock_pkg::PLL_KEY_SECOND_VALUE)
  ) pll_keys (
    .clock      (clock),
    .rst        (rst),
    .first_hit  (wr && hit_pll_k1),
    .value_hit  (wr && hit_pll),
    .second_hit (wr && hit_pll_k2),
    .read_hit   (rd && hit_pll),
    .wdata      (wdata[15:0]),
    .value_q    (pll_value),
    .commit_q   (pll_commit)
  );

  key_sequencer #(
    .FIRST_KEY  (power_clock_pkg::POWER_KEY_FIRST_VALUE),
    .SECOND_KEY (power_clock_pkg::POWER_KEY_SECOND_VALUE)
  ) power_keys (
    .clock      (clock),
    .rst        (rst),
    .first_hit  (wr && hit_pwr_k1),
    .value_hit  (wr && hit_pwr),
    .second_hit (wr && hit_pwr_k2),
    .read_hit   (rd && hit_pwr),
    .wdata      (wdata[15:0]),
    .value_q    (pwr_value),
    .commit_q   (pwr_commit)
  );

  key_sequencer #(
    .FIRST_KEY  (power_clock_pkg::PERIPH_KEY_FIRST_VALUE),
    .SECOND_KEY (power_clock_pkg::PERIPH_KEY_SECOND_VALUE)
  ) periph_keys (
    .clock      (clock),
    .rst        (rst),
    .first_hit  (wr && hit_per_k1),
    .value_hit  (wr && hit_per),
    .second_hit (wr && hit_per_k2),
    .read_hit   (rd && hit_per),
    .wdata      (wdata[15:0]),
    .value_q    (per_value),
    .commit_q   (per_commit)
  );

  // Fields
  wire [2:0] operating_mode_field =
    power_mode_q[power_clock_pkg::MODE_MSB:power_clock_pkg::MODE_LSB];
  wire [2:0] core_clock_divider =
    power_mode_q[power_clock_pkg::CORE_DIV_MSB:power_clock_pkg::CORE_DIV_LSB];
  wire [2:0] new_mode =
    pwr_value[power_clock_pkg::MODE_MSB:power_clock_pkg::MODE_LSB];
  wire       pll_reference_select =
    pll_config_q[power_clock_pkg::PLL_REF_BIT];
  wire [1:0] clock_source_mode =
    pll_config_q[power_clock_pkg::SOURCE_MSB:power_clock_pkg::SOURCE_LSB];
  wire       pwm_power_on = periph_control_q[power_clock_pkg::PWM_ON_BIT];
  wire       serial_periph_power_on =
    periph_control_q[power_clock_pkg::SPI_ON_BIT];
  wire [1:0] serial_periph_clock_divider =
    periph_control_q[power_clock_pkg::SPI_DIV_MSB:power_clock_pkg::SPI_DIV_LSB];
  wire       second_twowire_power_on =
    periph_control_q[power_clock_pkg::TWOWIRE2_ON_BIT];
  wire [1:0] second_twowire_clock_divider = periph_control_q[
    power_clock_pkg::TWOWIRE2_DIV_MSB:power_clock_pkg::TWOWIRE2_DIV_LSB];
  wire       first_twowire_power_on =
    periph_control_q[power_clock_pkg::TWOWIRE1_ON_BIT];
  wire [1:0] first_twowire_clock_divider = periph_control_q[
    power_clock_pkg::TWOWIRE1_DIV_MSB:power_clock_pkg::TWOWIRE1_DIV_LSB];

  // Mode sequencing
  power_clock_pkg::mode_state_t state_q;
  power_clock_pkg::mode_state_t state_d;
  logic [CW-1:0] recover_q;
  logic [CW-1:0] recover_load;

  wire ext_wake  = |external_wake_interrupts;
  wire any_wake  = ext_wake | core_wake_request;
  wire in_active = state_q == power_clock_pkg::ST_ACTIVE;

  // Linear between the divider-0 and divider-7 figures
  wire [CW-1:0] pause_load = CW'(power_clock_pkg::PAUSE_CD0_CYCLES +
    ((power_clock_pkg::SLOW_CD7_CYCLES - power_clock_pkg::PAUSE_CD0_CYCLES)
    * int'(core_clock_divider)) / power_clock_pkg::CORE_DIV_TOP);
  wire [CW-1:0] nap_load = CW'(power_clock_pkg::NAP_CD0_CYCLES +
    ((power_clock_pkg::SLOW_CD7_CYCLES - power_clock_pkg::NAP_CD0_CYCLES)
    * int'(core_clock_divider)) / power_clock_pkg::CORE_DIV_TOP);

  always_comb
  begin
    state_d = state_q;
    recover_load = CW'(1);
    unique case (state_q)
      power_clock_pkg::ST_ACTIVE:
        if (pwr_commit)
          unique case (new_mode)
            power_clock_pkg::MODE_PAUSE: state_d = power_clock_pkg::ST_PAUSE;
            power_clock_pkg::MODE_NAP:   state_d = power_clock_pkg::ST_NAP;
            power_clock_pkg::MODE_SLEEP: state_d = power_clock_pkg::ST_SLEEP;
            power_clock_pkg::MODE_STOP:  state_d = power_clock_pkg::ST_STOP;
            default:                     state_d = power_clock_pkg::ST_ACTIVE;
          endcase
      power_clock_pkg::ST_PAUSE:
      begin
        recover_load = pause_load;
        if (any_wake) state_d = power_clock_pkg::ST_RECOVER;
      end
      power_clock_pkg::ST_NAP:
      begin
        recover_load = nap_load;
        if (any_wake) state_d = power_clock_pkg::ST_RECOVER;
      end
      power_clock_pkg::ST_SLEEP:
      begin
        recover_load = CW'(SLEEP_RECOVERY_CYCLES);
        if (ext_wake) state_d = power_clock_pkg::ST_RECOVER;
      end
      power_clock_pkg::ST_STOP:
      begin
        recover_load = CW'(STOP_RECOVERY_CYCLES);
        if (ext_wake) state_d = power_clock_pkg::ST_RECOVER;
      end
      power_clock_pkg::ST_RECOVER:
        if (recover_q <= CW'(1)) state_d = power_clock_pkg::ST_ACTIVE;
      default: state_d = power_clock_pkg::ST_ACTIVE;
    endcase
  end

  wire wake_event = (state_d == power_clock_pkg::ST_RECOVER) &&
                    (state_q != power_clock_pkg::ST_RECOVER);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_q   <= power_clock_pkg::ST_ACTIVE;
      recover_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      if (wake_event)
        recover_q <= recover_load;
      else if (recover_q != '0)
        recover_q <= recover_q - 1'b1;
    end
  end

  // Protected registers
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      power_mode_q     <= power_clock_pkg::POWER_MODE_RESET;
      pll_config_q     <= power_clock_pkg::PLL_CONFIG_RESET;
      periph_control_q <= power_clock_pkg::PERIPH_CONTROL_RESET;
    end
    else
    begin
      if (wake_event)
        power_mode_q <= power_mode_q & ~power_clock_pkg::POWER_MODE_MASK
                        | (power_mode_q & 8'h07);
      else if (pwr_commit)
        power_mode_q <= pwr_value[7:0] & power_clock_pkg::POWER_MODE_MASK;
      if (pll_commit)
        pll_config_q <= pll_value[7:0] & power_clock_pkg::PLL_CONFIG_MASK;
      if (per_commit)
        periph_control_q <= per_value & power_clock_pkg::PERIPH_CONTROL_MASK;
    end
  end

  // Clock generation
  wire use_external = clock_source_mode == power_clock_pkg::SOURCE_EXTERNAL;
  wire source_tick  = use_external ? external_clock_tick : pll_output_clock;
  // Lock loss gates the core when it runs from the PLL, without waiting for software
  wire core_run     = in_active && (use_external || pll_locked);
  wire periph_run   = in_active || state_q == power_clock_pkg::ST_PAUSE ||
                      state_q == power_clock_pkg::ST_RECOVER;
  wire [2:0] spi_shift = {1'b0, serial_periph_clock_divider};

  function automatic logic [2:0] twowire_shift(input logic [1:0] code);
    unique case (code)
      2'h0: twowire_shift = 3'h0;
      2'h1: twowire_shift = 3'h2;
      2'h2: twowire_shift = 3'h3;
      2'h3: twowire_shift = 3'h5;
    endcase
  endfunction

  tick_divider core_div (
    .clock   (clock),
    .rst     (rst),
    .tick_in (source_tick),
    .run     (core_run),
    .shift   (core_clock_divider),
    .tick_q  (core_clock_tick_q)
  );

  tick_divider spi_div (
    .clock   (clock),
    .rst     (rst),
    .tick_in (source_tick),
    .run     (periph_run && serial_periph_power_on),
    .shift   (spi_shift),
    .tick_q  (serial_periph_clock_tick_q)
  );

  tick_divider first_twowire_div (
    .clock   (clock),
    .rst     (rst),
    .tick_in (source_tick),
    .run     (periph_run && first_twowire_power_on),
    .shift   (twowire_shift(first_twowire_clock_divider)),
    .tick_q  (first_twowire_clock_tick_q)
  );

  tick_divider second_twowire_div (
    .clock   (clock),
    .rst     (rst),
    .tick_in (source_tick),
    .run     (periph_run && second_twowire_power_on),
    .shift   (twowire_shift(second_twowire_clock_divider)),
    .tick_q  (second_twowire_clock_tick_q)
  );

  // Status outputs and PLL interrupt
  logic lock_seen_q;
  wire  lock_lost = lock_seen_q && !pll_locked;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      pwm_enable_q             <= 1'b0;
      serial_periph_enable_q   <= 1'b0;
      first_twowire_enable_q   <= 1'b0;
      second_twowire_enable_q  <= 1'b0;
      core_running_q           <= 1'b0;
      peripherals_running_q    <= 1'b0;
      pll_running_q            <= 1'b0;
      crystal_timers_running_q <= 1'b0;
      wake_irqs_enabled_q      <= 1'b0;
      clock_source_external_q  <= 1'b0;
      pll_reference_internal_q <= 1'b0;
      lock_seen_q              <= 1'b0;
      pll_irq_q                <= 1'b0;
    end
    else
    begin
      pwm_enable_q            <= periph_run && pwm_power_on;
      serial_periph_enable_q  <= periph_run && serial_periph_power_on;
      first_twowire_enable_q  <= periph_run && first_twowire_power_on;
      second_twowire_enable_q <= periph_run && second_twowire_power_on;
      core_running_q          <= core_run;
      peripherals_running_q   <= periph_run;
      pll_running_q           <= state_q != power_clock_pkg::ST_SLEEP &&
                                 state_q != power_clock_pkg::ST_STOP;
      crystal_timers_running_q <= state_q != power_clock_pkg::ST_STOP;
      wake_irqs_enabled_q     <= 1'b1;
      clock_source_external_q <= use_external;
      pll_reference_internal_q <= pll_reference_select;
      lock_seen_q             <= pll_locked;
      // Ack only counts once lock is back; a new loss wins over it
      if (lock_lost)
        pll_irq_q <= 1'b1;
      else if (pll_irq_ack && pll_locked)
        pll_irq_q <= 1'b0;
    end
  end

  // Register read
  wire [31:0] read_mux =
    hit_pwr ? {24'h000000, power_mode_q} :
    hit_pll ? {24'h000000, pll_config_q} :
    hit_per ? {16'h0000, periph_control_q} : 32'h00000000;

  always_ff @(posedge clock)
  begin
    if (rst)
      rdata_q <= 32'h00000000;
    else
      rdata_q <= rd ? read_mux : 32'h00000000;
  end
endmodule

/* File: power_clock_control_asserts.sv */
`timescale 1ns/1ps
module power_clock_control_asserts (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic [31:0] addr,
  input wire logic        rd,
  input wire logic [31:0] rdata_q,
  input wire logic        pll_locked,
  input wire logic [3:0]  external_wake_interrupts,
  input wire logic        core_running_q,
  input wire logic        peripherals_running_q,
  input wire logic        pll_running_q,
  input wire logic        crystal_timers_running_q,
  input wire logic        wake_irqs_enabled_q,
  input wire logic        clock_source_external_q,
  input wire logic        pll_reference_internal_q,
  input wire logic        pll_irq_q
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (rst);
  sequence pll_read_s;
    rd && addr == power_clock_pkg::PLL_CONFIG_ADDR;
  endsequence
  // Flags lag the register by one flop, so compare one cycle on
  sequence pll_seen_s;
    pll_read_s ##1 1'b1;
  endsequence
  pll_reserved_a: assert property (pll_read_s |=>
    (rdata_q & 32'hffffffdc) == 32'h0)
    else $error("pll config reserved bits not zero");
  mode_reserved_a: assert property (
    rd && addr == power_clock_pkg::POWER_MODE_ADDR |=>
    (rdata_q & 32'hffffff88) == 32'h0)
    else $error("power mode reserved bits not zero");
  pll_ref_a: assert property (pll_seen_s |=>
    pll_reference_internal_q == $past(rdata_q[5]))
    else $error("reference flag differs from bit 5");
  source_ext_a: assert property (pll_seen_s |=>
    clock_source_external_q == ($past(rdata_q[1:0]) == 2'h3))
    else $error("source flag differs from source field");
  deep_wake_a: assert property (
    wake_irqs_enabled_q && !pll_running_q && |external_wake_interrupts
    |-> ##[1:2] peripherals_running_q)
    else $error("external line did not wake");
  mode_depth_a: assert property (
    (!crystal_timers_running_q |-> !pll_running_q) and
    (!pll_running_q |-> !peripherals_running_q) and
    (!peripherals_running_q |-> !core_running_q))
    else $error("running flags out of order");
  lock_halt_a: assert property (
    $fell(pll_locked) && !clock_source_external_q |->
    ##[1:2] !core_running_q)
    else $error("core not halted on lock loss");
  lock_irq_a: assert property ($fell(pll_locked) |->
    ##[1:2] pll_irq_q)
    else $error("no pll interrupt on lock loss");
  irq_hold_a: assert property (pll_irq_q && !pll_locked |=>
    pll_irq_q)
    else $error("pll interrupt cleared while unlocked");
endmodule

bind power_clock_control power_clock_control_asserts asserts_u (
  .clock, .rst, .addr, .rd, .rdata_q, .pll_locked,
  .external_wake_interrupts, .core_running_q, .peripherals_running_q,
  .pll_running_q, .crystal_timers_running_q, .wake_irqs_enabled_q,
  .clock_source_external_q, .pll_reference_internal_q, .pll_irq_q
);

/* File: power_clock_control_test.sv */
`timescale 1ns/1ps
module power_clock_control_test;
  // Shift nibbles: core, spi, first and second two-wire; e skips
  typedef struct packed {
    logic [1:0]  grp;
    logic [15:0] val;
    logic [15:0] rb;
    logic [15:0] sh;
  } row_t;
  // Core divider set first so peripheral clocks never run slower
  localparam row_t rows [7] = '{
    '{2'd1, 16'h0087, 16'h0007, 16'h7e0e},
    '{2'd2, 16'hffff, 16'h09ff, 16'h7355},
    '{2'd2, 16'h096e, 16'h096e, 16'h7132},
    '{2'd0, 16'h00ff, 16'h0023, 16'h8243},
    '{2'd0, 16'h0001, 16'h0001, 16'h7132},
    '{2'd1, 16'h000b, 16'h0003, 16'h3132},
    '{2'd2, 16'h0000, 16'h0000, 16'h3eee}};
  logic [31:0] k1a [3] = '{32'hffff0410, 32'hffff0404, 32'hffff0434};
  logic [15:0] k1v [3] = '{16'h00aa, 16'h0001, 16'h0076};
  logic [15:0] k2v [3] = '{16'h0055, 16'h00f4, 16'h00b1};
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] addr = 32'h0;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        pll_locked = 1'b1;
  logic [3:0]  wake = 4'h0;
  logic        core_wake = 1'b0;
  logic        irq_ack = 1'b0;
  logic [31:0] rdata_q;
  logic [3:0]  tk;
  logic [3:0]  en;
  logic [3:0]  run;
  logic        ext_src;
  logic        ref_int;
  logic        pll_irq;
  logic        ext_tick = 1'b0;
  logic        wake_en;
  int          n_fail = 0;
  int          check_count = 0;

  power_clock_control #(
    .SLEEP_RECOVERY_CYCLES(20),
    .STOP_RECOVERY_CYCLES(30)
  ) dut (
    .clock(clock), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata_q(rdata_q), .pll_output_clock(1'b1),
    .external_clock_tick(ext_tick), .pll_locked(pll_locked),
    .external_wake_interrupts(wake), .core_wake_request(core_wake),
    .pll_irq_ack(irq_ack), .core_clock_tick_q(tk[0]),
    .serial_periph_clock_tick_q(tk[1]),
    .first_twowire_clock_tick_q(tk[2]),
    .second_twowire_clock_tick_q(tk[3]), .pwm_enable_q(en[3]),
    .serial_periph_enable_q(en[2]), .second_twowire_enable_q(en[1]),
    .first_twowire_enable_q(en[0]), .core_running_q(run[3]),
    .peripherals_running_q(run[2]), .pll_running_q(run[1]),
    .crystal_timers_running_q(run[0]), .wake_irqs_enabled_q(wake_en),
    .clock_source_external_q(ext_src),
    .pll_reference_internal_q(ref_int), .pll_irq_q(pll_irq));

  always #2.5 clock = ~clock;

  // Half-rate external pin so its rows differ from the PLL ones
  always @(posedge clock)
    ext_tick <= ~ext_tick;

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    if (n_fail == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Returns just past an edge so flags read here have settled
  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  task automatic wreg(input logic [31:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= {16'h0, d};
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask

  task automatic rreg(input string what, input logic [31:0] a,
                      input logic [31:0] exp);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 check(what, exp, rdata_q);
  endtask

  task automatic keyed(input int g, input logic [15:0] v);
    wreg(k1a[g], k1v[g]);
    wreg(k1a[g] + 32'h4, v);
    wreg(k1a[g] + 32'h8, k2v[g]);
    cyc(2);
  endtask

  // Divider phase is unknown, so one tick either way is allowed
  task automatic ticks(input logic [15:0] sh);
    int c [4] = '{0, 0, 0, 0};
    int e;
    repeat (256)
    begin
      cyc(1);
      for (int i = 0; i < 4; i++)
        c[i] += int'(tk[i]);
    end
    for (int i = 0; i < 4; i++)
    begin
      e = 256 >> sh[12 - 4 * i +: 4];
      if (sh[12 - 4 * i +: 4] != 4'he)
        check("tick count", 1'b1, c[i] >= e - 1 && c[i] <= e + 1);
    end
  endtask

  task automatic low_mode(input logic [2:0] code, input int line,
                          input int load);
    logic [3:0] exp;
    int         n;
    exp = {1'b0, code == 3'h1, code < 3'h3, code < 3'h4};
    keyed(1, {9'h0, code, 4'h0});
    cyc(3);
    check("run flags", exp, run);
    check("wake enabled", 1'b1, wake_en);
    if (line >= 0)
    begin
      core_wake <= 1'b1;
      cyc(1);
      core_wake <= 1'b0;
      cyc(5);
      check("no core wake", exp, run);
      wake[line] <= 1'b1;
    end
    else
      core_wake <= 1'b1;
    for (n = 0; n < 2000 && run[3] !== 1'b1; n++)
      @(negedge clock);
    if (n == 2000)
    begin
      n_fail++;
      wrap_up();
    end
    cyc(1);
    wake <= 4'h0;
    core_wake <= 1'b0;
    check("recovery", 1'b1, n >= load && n <= load + 4);
    rreg("mode after wake", 32'hffff0408, 32'h0);
  endtask

  initial
  begin
    row_t r;
    cyc(6);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      r = rows[i];
      keyed(r.grp, r.val);
      rreg("readback", k1a[r.grp] + 32'h4, {16'h0, r.rb});
      if (r.grp == 2'd0)
        check("pll flags", {r.rb[5], r.rb[1:0] == 2'h3}, {ref_int, ext_src});
      if (r.grp == 2'd2)
        check("enables", {r.rb[11], r.rb[8], r.rb[5], r.rb[2]}, en);
      ticks(r.sh);
    end
    rst <= 1'b1;
    cyc(3);
    rst <= 1'b0;
    rreg("pll reset", 32'hffff0414, 32'h21);
    rreg("periph reset", 32'hffff0438, 32'h4);
    rreg("key read", 32'hffff0410, 32'h0);
    rreg("unmapped", 32'hffff0400, 32'h0);
    check("reset enables", 4'h1, en);
    wreg(32'hffff0414, 16'h0001);
    wreg(32'hffff0438, 16'h0000);
    wreg(32'hffff0408, 16'h0010);
    wreg(k1a[0], 16'h00aa);
    wreg(32'hffff0414, 16'h0001);
    wreg(32'hffff0418, 16'h0054);
    wreg(k1a[0], 16'h00aa);
    rreg("pll mid", 32'hffff0414, 32'h21);
    wreg(32'hffff0414, 16'h0001);
    wreg(32'hffff0418, 16'h0055);
    wreg(k1a[0], 16'h00ab);
    wreg(32'hffff0414, 16'h0001);
    wreg(32'hffff0418, 16'h0055);
    cyc(2);
    rreg("pll kept", 32'hffff0414, 32'h21);
    rreg("periph kept", 32'hffff0438, 32'h4);
    rreg("mode kept", 32'hffff0408, 32'h0);
    low_mode(3'h1, -1, 46);
    low_mode(3'h2, -1, 57);
    for (int i = 0; i < 4; i++)
      low_mode(i < 2 ? 3'h3 : 3'h4, i, i < 2 ? 20 : 30);
    pll_locked <= 1'b0;
    irq_ack <= 1'b1;
    cyc(3);
    check("halt and irq", 2'b01, {run[3], pll_irq});
    pll_locked <= 1'b1;
    cyc(3);
    irq_ack <= 1'b0;
    check("relock", 2'b10, {run[3], pll_irq});
    wrap_up();
  end
endmodule
